/* File: icd_map.vh */
// constants for the interrupt command decoder: command codes, field positions, reset values
// assumes a single 50 MHz clock domain; included by bare name
`ifndef ICD_MAP_VH
`define ICD_MAP_VH
`define ICD_OP_CLR_ISR_HI 4'h6
`define ICD_OP_CLR_ISR_ALL 5'h0e
`define ICD_OP_CLR_ISR_ONE 5'h0f
`define ICD_OP_MODE_LOW 3'h4
`define ICD_OP_MODE_HIGH 4'ha
`define ICD_OP_PRE_MASK 4'hb
`define ICD_OP_PRE_ACLR 4'hc
`define ICD_OP_PRE_VEC 3'h7
`define ICD_MM_KEEP 2'h0
`define ICD_MM_SET 2'h1
`define ICD_MM_CLR 2'h2
`define ICD_MM_BIT 7
`define ICD_MODE_RST 8'h00
`define ICD_ISR_RST 8'h00
`define ICD_MASK_RST 8'hff
`define ICD_ACLR_RST 8'h00
`define ICD_TGT_NONE 2'h0
`define ICD_TGT_MASK 2'h1
`define ICD_TGT_ACLR 2'h2
`define ICD_TGT_VEC 2'h3
`define ICD_VEC_DEPTH 4
`endif

/* File: icd_prio.v */
// highest-priority set bit finder for an 8-bit vector
// pure combinational; bit 0 is taken as the highest priority level
`timescale 1ns/1ps
`default_nettype none
module icd_prio (
	input wire [7:0] bits_in, // candidate bits
	output reg [7:0] onehot_out, // one-hot of the winning bit, zero when none
	output reg any_out // at least one bit set
);
	integer i;
	// scan from the lowest priority upward so the last hit wins
	always @* begin
		onehot_out = 8'h00;
		any_out = 1'b0;
		for (i = 7; i >= 0; i = i - 1) begin
			if (bits_in[i]) begin
				onehot_out = 8'h00;
				onehot_out[i] = 1'b1;
				any_out = 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

/* File: icd_core.v */
// interrupt command decoder: command port, data port, mode, in-service, mask,
// auto-clear and vector memory with acknowledge readout
// assumes strobes and data come from logic on clk_in (no synchronisers needed);
// one group instance; the command and data strobes are the paired ports of a group
//
// Overview of operation
// - 0110xxxx clears highest-priority in-service bit only
// - 01110xxx clears all in-service bits
// - 01111bbb clears one selected in-service bit
// - 100xxxxx loads mode bits four to zero
// - 1010 command loads mode bits six, five
// - low two bits keep/set/clear master mask
// - 1011 preselects mask register for data writes
// - 1100 preselects auto-clear register for data writes
// - preselect target survives intervening reads
// - mask/auto-clear preselects leave mode untouched
// - 111 command loads level byte count, targets level
// - low three bits pick vector level
// - count code n means n+1 bytes
// - count limits readout, not memory writes
// - vectors read out in written order
// - bit selector is a plain binary index
// - commands on command port, preselects target data port
// - in-service bit without auto-clear fences lower requests
`timescale 1ns/1ps
`default_nettype none
`include "icd_map.vh"
module icd_core (
	input wire clk_in, // 50 MHz system clock
	input wire rst_n_in, // asynchronous reset, active low
	input wire cmd_wr_in, // one-cycle write strobe, command port low byte
	input wire data_wr_in, // one-cycle write strobe, data port
	input wire data_rd_in, // one-cycle read strobe, data port (no side effect)
	input wire [7:0] wdata_in, // write data byte
	input wire [7:0] req_in, // latched pending requests, one per level
	input wire ack_in, // one-cycle pulse: acknowledge cycle byte request
	output reg [7:0] mode_out, // mode register
	output reg [7:0] in_service_bits_out, // in-service bits
	output reg [7:0] request_mask_bits_out, // mask register
	output reg [7:0] auto_clear_select_out, // auto-clear register
	output reg [1:0] target_out, // current data-port write target
	output reg [7:0] vec_byte_out, // vector byte answering an acknowledge
	output reg vec_valid_out, // pulse with vec_byte_out
	output reg [2:0] vec_level_out, // level served by vec_byte_out
	output reg irq_out // unmasked request above the fence
);
	reg [7:0] vmem [0:31]; // vector memory, four bytes per level
	reg [1:0] count_r [0:7]; // byte count code per level
	reg [1:0] wptr_r [0:7]; // write position per level
	reg [1:0] rptr_r [0:7]; // readout position per level
	reg [2:0] sel_level_r; // preselected vector level
	reg [1:0] target_nxt;
	wire [7:0] isr_hi; // one-hot highest set in-service bit
	wire [7:0] req_live; // unmasked requests
	wire [7:0] req_hi; // winning request
	wire req_any;
	wire [7:0] fence; // levels at or below a fencing in-service bit
	wire [7:0] sel_bit; // decoded bit selector
	reg [2:0] win_level; // binary of the winning request
	integer k; // index of the winning-level scan only
	integer j; // reset loop index, kept apart so k has a single driver

	assign sel_bit = 8'h01 << wdata_in[2:0];
	assign req_live = req_in & ~request_mask_bits_out & ~fence;
	// a fencing bit blocks its own and every lower-priority (higher-index) level
	assign fence[0] = in_service_bits_out[0] & ~auto_clear_select_out[0];
	genvar g;
	generate
		for (g = 1; g < 8; g = g + 1) begin : fence_chain
			assign fence[g] = fence[g-1] | (in_service_bits_out[g] & ~auto_clear_select_out[g]);
		end
	endgenerate

	icd_prio u_isr_prio (
		.bits_in(in_service_bits_out),
		.onehot_out(isr_hi),
		.any_out() // a clear of an empty set is harmless, so no flag needed
	);
	icd_prio u_req_prio (
		.bits_in(req_live),
		.onehot_out(req_hi),
		.any_out(req_any)
	);

	// binary index of the winning request
	always @* begin
		win_level = 3'h0;
		for (k = 0; k < 8; k = k + 1) begin
			if (req_hi[k]) begin
				win_level = k[2:0];
			end
		end
	end

	// target only moves on a command write; reads never touch it
	always @* begin
		target_nxt = target_out;
		if (cmd_wr_in) begin
			target_nxt = `ICD_TGT_NONE; // any other command ends the preselect
			if (wdata_in[7:4] == `ICD_OP_PRE_MASK) begin
				target_nxt = `ICD_TGT_MASK;
			end else if (wdata_in[7:4] == `ICD_OP_PRE_ACLR) begin
				target_nxt = `ICD_TGT_ACLR;
			end else if (wdata_in[7:5] == `ICD_OP_PRE_VEC) begin
				target_nxt = `ICD_TGT_VEC;
			end
		end
	end

	// command decode and register updates, all applied at the strobe edge
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mode_out <= `ICD_MODE_RST;
			in_service_bits_out <= `ICD_ISR_RST;
			request_mask_bits_out <= `ICD_MASK_RST;
			auto_clear_select_out <= `ICD_ACLR_RST;
			target_out <= `ICD_TGT_NONE;
			sel_level_r <= 3'h0;
			vec_byte_out <= 8'h00;
			vec_valid_out <= 1'b0;
			vec_level_out <= 3'h0;
			irq_out <= 1'b0;
			for (j = 0; j < 8; j = j + 1) begin
				count_r[j] <= 2'h0;
				wptr_r[j] <= 2'h0;
				rptr_r[j] <= 2'h0;
			end
		end else begin
			target_out <= target_nxt;
			vec_valid_out <= 1'b0;
			irq_out <= req_any & ~mode_out[`ICD_MM_BIT];
			if (cmd_wr_in) begin
				if (wdata_in[7:4] == `ICD_OP_CLR_ISR_HI) begin
					in_service_bits_out <= in_service_bits_out & ~isr_hi;
				end else if (wdata_in[7:3] == `ICD_OP_CLR_ISR_ALL) begin
					in_service_bits_out <= 8'h00;
				end else if (wdata_in[7:3] == `ICD_OP_CLR_ISR_ONE) begin
					in_service_bits_out <= in_service_bits_out & ~sel_bit;
				end else if (wdata_in[7:5] == `ICD_OP_MODE_LOW) begin
					mode_out[4:0] <= wdata_in[4:0];
				end else if (wdata_in[7:4] == `ICD_OP_MODE_HIGH) begin
					mode_out[6:5] <= wdata_in[3:2];
					// illegal code 11 is ignored like keep
					if (wdata_in[1:0] == `ICD_MM_SET) begin
						mode_out[`ICD_MM_BIT] <= 1'b1;
					end else if (wdata_in[1:0] == `ICD_MM_CLR) begin
						mode_out[`ICD_MM_BIT] <= 1'b0;
					end
				end else if (wdata_in[7:5] == `ICD_OP_PRE_VEC) begin
					count_r[wdata_in[2:0]] <= wdata_in[4:3];
					sel_level_r <= wdata_in[2:0];
					wptr_r[wdata_in[2:0]] <= 2'h0;
					rptr_r[wdata_in[2:0]] <= 2'h0;
				end
				// mask and auto-clear preselects fall through: mode untouched
			end else if (data_wr_in) begin
				case (target_out)
					`ICD_TGT_MASK: begin
						request_mask_bits_out <= wdata_in;
					end
					`ICD_TGT_ACLR: begin
						auto_clear_select_out <= wdata_in;
					end
					`ICD_TGT_VEC: begin
						// write position wraps; count never blocks the write
						wptr_r[sel_level_r] <= wptr_r[sel_level_r] + 2'h1;
					end
					default: begin
					end
				endcase
			end else if (ack_in && req_any) begin
				vec_byte_out <= vmem[{win_level, rptr_r[win_level]}];
				vec_valid_out <= 1'b1;
				vec_level_out <= win_level;
				if (rptr_r[win_level] == count_r[win_level]) begin
					// last byte: service starts, fence unless auto-cleared
					rptr_r[win_level] <= 2'h0;
					if (!auto_clear_select_out[win_level]) begin
						in_service_bits_out <= in_service_bits_out | req_hi;
					end
				end else begin
					rptr_r[win_level] <= rptr_r[win_level] + 2'h1;
				end
			end
		end
	end

	// vector memory write port, no reset so it maps onto a plain array
	always @(posedge clk_in) begin
		if (!cmd_wr_in && data_wr_in && target_out == `ICD_TGT_VEC) begin
			vmem[{sel_level_r, wptr_r[sel_level_r]}] <= wdata_in;
		end
	end
endmodule
`default_nettype wire

/* File: icd_core_assertions.sv */
// port checker for the command decoder
// bound to icd_core; single clk_in domain
`timescale 1ns/1ps
`default_nettype none
module icd_core_chk (
	input wire clk_in,
	input wire rst_n_in,
	input wire cmd_wr_in,
	input wire data_rd_in,
	input wire [7:0] wdata_in,
	input wire [7:0] mode_out,
	input wire [7:0] in_service_bits_out,
	input wire [1:0] target_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// the mode-high command, step one of the master mask checks
	sequence s_mhi;
		cmd_wr_in && wdata_in[7:4] == 4'ha;
	endsequence
	// bit 0 is the highest level, so the lowest set bit must be the one that goes
	a_clr_hi_isr: assert property (
		cmd_wr_in && wdata_in[7:4] == 4'h6 |=>
		in_service_bits_out == ($past(in_service_bits_out) & ($past(in_service_bits_out) - 8'h01))
	) else $error("wrong isr bit cleared");
	a_clr_all_isr: assert property (
		cmd_wr_in && wdata_in[7:3] == 5'h0e |=> in_service_bits_out == 8'h00
	) else $error("isr not cleared");
	a_clr_one_isr: assert property (
		cmd_wr_in && wdata_in[7:3] == 5'h0f |=> !in_service_bits_out[$past(wdata_in[2:0])]
	) else $error("isr bit kept");
	a_mode_low_load: assert property (
		cmd_wr_in && wdata_in[7:5] == 3'h4 |=>
		mode_out[4:0] == $past(wdata_in[4:0]) && mode_out[7:5] == $past(mode_out[7:5])
	) else $error("mode low wrong");
	a_mode_high_load: assert property (
		s_mhi |=> mode_out[6:5] == $past(wdata_in[3:2])
	) else $error("mode high wrong");
	a_master_set: assert property (
		s_mhi ##0 wdata_in[1:0] == 2'h1 |=> mode_out[7]
	) else $error("master not set");
	a_master_clr: assert property (
		s_mhi ##0 wdata_in[1:0] == 2'h2 |=> !mode_out[7]
	) else $error("master not cleared");
	a_pre_mask: assert property (
		cmd_wr_in && wdata_in[7:4] == 4'hb |=> target_out == 2'h1 && $stable(mode_out)
	) else $error("mask preselect");
	a_pre_aclr: assert property (
		cmd_wr_in && wdata_in[7:4] == 4'hc |=> target_out == 2'h2 && $stable(mode_out)
	) else $error("aclr preselect");
	// vector preselect targets the memory and leaves the mode alone
	a_pre_vec: assert property (
		cmd_wr_in && wdata_in[7:5] == 3'h7 |=> target_out == 2'h3 && $stable(mode_out)
	) else $error("vector preselect");
	a_read_keeps_tgt: assert property (
		data_rd_in && !cmd_wr_in |=> $stable(target_out)
	) else $error("read moved target");
endmodule
bind icd_core icd_core_chk i_icd_core_chk (
	.clk_in(clk_in),
	.rst_n_in(rst_n_in),
	.cmd_wr_in(cmd_wr_in),
	.data_rd_in(data_rd_in),
	.wdata_in(wdata_in),
	.mode_out(mode_out),
	.in_service_bits_out(in_service_bits_out),
	.target_out(target_out)
);
`default_nettype wire

/* File: icd_req_model.sv */
// request latch beside the decoder: raise pulses latch levels
// a level drops once its in-service bit rises, as on delivery
`timescale 1ns/1ps
`default_nettype none
module icd_req_model (
	input wire clk_in,
	input wire rst_n_in,
	input wire [7:0] raise_in,
	input wire [7:0] isr_in,
	output logic [7:0] req_out
);
	logic [7:0] isr_q; // last in-service bits, for edge finding
	// latch raises; clear on delivery so a count above one still finds its level
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			req_out <= 8'h00;
			isr_q <= 8'h00;
		end else begin
			isr_q <= isr_in;
			req_out <= (req_out | raise_in) & ~(isr_in & ~isr_q);
		end
	end
endmodule
`default_nettype wire

/* File: test_interrupt_command_decoder.sv */
// self-checking bench for icd_core driven through its command and data strobes
// assumes icd_map.vh on the include path and the request model beside it
`timescale 1ns/1ps
`default_nettype none
`include "icd_map.vh"
module test_interrupt_command_decoder;
	logic clk_in = 0, rst_n_in = 0, cmd_wr_in = 0, data_wr_in = 0, data_rd_in = 0, ack_in = 0;
	logic [7:0] wdata_in = 8'h00, req_in, raise = 8'h00, mode_out, in_service_bits, mask, aclr, vb;
	logic [1:0] tgt;
	logic [2:0] vl;
	logic vv, irq;
	integer n_fail = 0, comparisons = 0, i;
	localparam [39:0] MC = 40'h9f_ad_a3_a2_80; // mode commands, illegal 11 code among them
	localparam [39:0] ME = 40'h1f_ff_9f_1f_00; // mode expected after each
	always #10 clk_in = ~clk_in;
	icd_core i_icd_core (.clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_wr_in(cmd_wr_in),
		.data_wr_in(data_wr_in), .data_rd_in(data_rd_in), .wdata_in(wdata_in), .req_in(req_in),
		.ack_in(ack_in), .mode_out(mode_out), .in_service_bits_out(in_service_bits),
		.request_mask_bits_out(mask), .auto_clear_select_out(aclr), .target_out(tgt),
		.vec_byte_out(vb), .vec_valid_out(vv), .vec_level_out(vl), .irq_out(irq));
	icd_req_model i_icd_req_model (.clk_in(clk_in), .rst_n_in(rst_n_in), .raise_in(raise),
		.isr_in(in_service_bits), .req_out(req_in));
	task chk(input string nm, input [7:0] e, input [7:0] g);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one-cycle strobe on s with byte v; returns once outputs have settled
	task pulse(input int s, input [7:0] v);
		@(posedge clk_in);
		wdata_in <= v;
		case (s)
			0: cmd_wr_in <= 1'b1;
			1: data_wr_in <= 1'b1;
			2: data_rd_in <= 1'b1;
			3: raise <= v;
			default: ack_in <= 1'b1;
		endcase
		@(posedge clk_in);
		{cmd_wr_in, data_wr_in, data_rd_in, ack_in, raise} <= 12'h000;
		#1;
	endtask
	// acknowledge and wait a bounded time for the vector byte
	task ak(input [2:0] lv, input [7:0] b);
		pulse(4, 8'h00);
		for (i = 0; i < 8 && vv !== 1'b1; i++) @(posedge clk_in) #1;
		chk("vec_valid", 8'h01, {7'h00, vv});
		chk("vec_byte", b, vb);
		chk("vec_level", {5'h00, lv}, {5'h00, vl});
	endtask
	task conclude;
		$display("mismatches %0d comparisons %0d", n_fail, comparisons);
		if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// watchdog: the whole sequence needs under a hundred cycles
	initial begin
		repeat (20000) @(posedge clk_in);
		n_fail++;
		conclude;
	end
	initial begin
		repeat (16) @(posedge clk_in);
		rst_n_in <= 1'b1;
		#1;
		chk("rst_mode", `ICD_MODE_RST, mode_out);
		chk("rst_isr", `ICD_ISR_RST, in_service_bits);
		chk("rst_mask", `ICD_MASK_RST, mask);
		pulse(0, 8'hb7);
		pulse(2, 8'h00);
		chk("target", {6'h00, `ICD_TGT_MASK}, {6'h00, tgt});
		pulse(1, 8'h3c);
		pulse(1, 8'h00);
		chk("mask", 8'h00, mask);
		chk("mode", 8'h00, mode_out);
		pulse(0, 8'hc5);
		pulse(1, 8'h5a);
		chk("aclr", 8'h5a, aclr);
		pulse(1, 8'h00);
		chk("aclr", 8'h00, aclr);
		for (int k = 0; k < 5; k++) begin
			pulse(0, MC[39-8*k -: 8]);
			chk("mode", ME[39-8*k -: 8], mode_out);
		end
		// a non-preselect command ends the preselect; a data write then lands nowhere
		chk("target", {6'h00, `ICD_TGT_NONE}, {6'h00, tgt});
		pulse(1, 8'hee);
		chk("mask", 8'h00, mask);
		chk("aclr", 8'h00, aclr);
		pulse(0, 8'hea); // level 2, two bytes
		pulse(1, 8'h11);
		pulse(1, 8'h22);
		pulse(0, 8'he1);
		pulse(1, 8'h33);
		pulse(0, 8'he3);
		pulse(1, 8'h44);
		pulse(3, 8'h04);
		ak(3'h2, 8'h11);
		ak(3'h2, 8'h22);
		pulse(3, 8'h08);
		repeat (3) @(posedge clk_in) #1;
		chk("irq", 8'h00, {7'h00, irq});
		chk("isr", 8'h04, in_service_bits);
		pulse(3, 8'h02);
		repeat (3) @(posedge clk_in) #1;
		chk("irq", 8'h01, {7'h00, irq});
		ak(3'h1, 8'h33);
		chk("isr", 8'h06, in_service_bits);
		pulse(0, 8'h60);
		chk("isr", 8'h04, in_service_bits);
		pulse(0, 8'h7a);
		chk("isr", 8'h00, in_service_bits);
		ak(3'h3, 8'h44);
		pulse(0, 8'h7d);
		chk("isr", 8'h08, in_service_bits);
		pulse(0, 8'h70);
		chk("isr", 8'h00, in_service_bits);
		conclude;
	end
endmodule
`default_nettype wire
